//--- dv/pesc_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module pesc_asserts
	import pesc_pkg::*;
(
	// clock and reset
	input wire logic                                  clk,
	input wire logic                                  sys_rst,
	// control access
	input wire logic                                  accRdEn,
	input wire logic                                  accWrEn,
	input wire pesc_pkg::pesc_acc_e                   accKind,
	input wire logic [4:0]                            accIdx,
	input wire logic [31:0]                           accWrData,
	input wire logic [31:0]                           accRdData,
	// state
	input wire logic                                  groupEnable,
	input wire logic [pesc_pkg::PESC_NUM_CNT-1:0][5:0]  eventSelect,
	input wire logic [pesc_pkg::PESC_NUM_CNT-1:0][63:0] counterValue,
	input wire logic                                  coreHalted
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_halt_hold;
		coreHalted && !accWrEn |=> $stable(counterValue);
	endproperty
	a_halt_hold: assert property (p_halt_hold) else $error("counter moved while halted");
	property p_group_hold;
		!groupEnable && !accWrEn |=> $stable(counterValue);
	endproperty
	a_group_hold: assert property (p_group_hold) else $error("counter moved while group off");
	property p_sel_first;
		accWrEn && accKind == PESC_ACC_SEL && accIdx == 5'h03 |=>
			eventSelect[0] == (($past(accWrData) > 32'h0000_0032) ? PESC_EVT_MAX : 6'($past(accWrData)));
	endproperty
	a_sel_first: assert property (p_sel_first) else $error("first selector write wrong");
	property p_sel_last;
		accWrEn && accKind == PESC_ACC_SEL && accIdx == 5'h06 && accWrData > 32'h0000_0032 |=>
			eventSelect[3] == PESC_EVT_MAX;
	endproperty
	a_sel_last: assert property (p_sel_last) else $error("last selector not clamped");
	property p_sel_none;
		eventSelect[0] == PESC_EVT_NONE && !accWrEn |=> $stable(counterValue[0]);
	endproperty
	a_sel_none: assert property (p_sel_none) else $error("selector zero counted");
	property p_cycles;
		eventSelect[1] == PESC_EVT_CYCLES && groupEnable && !coreHalted && !accWrEn |=>
			counterValue[1] == $past(counterValue[1]) + 64'h0000_0000_0000_0001;
	endproperty
	a_cycles: assert property (p_cycles) else $error("cycle event did not add one");
	property p_rsv_read;
		accRdEn && accKind != PESC_ACC_GROUP && !(accIdx inside {[5'h03:5'h06]}) |=> accRdData == 32'h0000_0000;
	endproperty
	a_rsv_read: assert property (p_rsv_read) else $error("unimplemented slot read nonzero");
	property p_group_read;
		accRdEn && accKind == PESC_ACC_GROUP |=> accRdData == {31'h0000_0000, $past(groupEnable)};
	endproperty
	a_group_read: assert property (p_group_read) else $error("group enable read wrong");
	property p_read_old;
		accRdEn && accKind == PESC_ACC_CNT_LO && accIdx == 5'h03 |=> accRdData == $past(counterValue[0][31:0]);
	endproperty
	a_read_old: assert property (p_read_old) else $error("counter read not before step");
	c_halt: cover property (coreHalted && !accWrEn);
	c_clamp: cover property (accWrEn && accKind == PESC_ACC_SEL && accWrData > 32'h0000_0032);
	c_group_off: cover property (!groupEnable);
endmodule : pesc_asserts
bind perf_event_select_count pesc_asserts u_asserts (.clk(clk), .sys_rst(sys_rst), .accRdEn(accRdEn),
	.accWrEn(accWrEn), .accKind(accKind), .accIdx(accIdx), .accWrData(accWrData), .accRdData(accRdData),
	.groupEnable(groupEnable), .eventSelect(eventSelect), .counterValue(counterValue), .coreHalted(coreHalted));
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
	import pesc_pkg::*;
	logic                          clk = 0, sys_rst = 1, rd = 0, wr = 0, halt = 1, mie = 0, isd = 0, grpEn, grp = 1;
	pesc_acc_e                     kind = PESC_ACC_CNT_LO;
	logic [4:0]                    idx = 5'h00;
	logic [2:0]                    tmr = 3'h0;
	logic [31:0]                   wdata = 32'h0000_0000, rdData, rdExp = 32'h0000_0000;
	logic [1:0]                    ev [PESC_NUM_EVT];
	logic [PESC_NUM_CNT-1:0][5:0]  selOut;
	logic [PESC_NUM_CNT-1:0][63:0] cntOut;
	logic [5:0]                    sel [PESC_NUM_CNT];
	logic [63:0]                   cnt [PESC_NUM_CNT];
	int                            err_count = 0, samples_checked = 0, ticks = 0;
	perf_event_select_count dut (.clk(clk), .sys_rst(sys_rst), .accRdEn(rd), .accWrEn(wr), .accKind(kind),
		.accIdx(idx), .accWrData(wdata), .accRdData(rdData), .groupEnable(grpEn), .eventSelect(selOut),
		.counterValue(cntOut), .coreHalted(halt), .mstatusMie(mie), .icacheHit(ev[2][0]), .icacheMiss(ev[3][0]),
		.alignedCount(ev[7]), .decodedCount(ev[8]), .commit16Count(ev[5]), .commit32Count(ev[6]),
		.mulCommit(ev[9][0]), .divCommit(ev[10][0]), .loadCommit(ev[11][0]), .storeCommit(ev[12][0]),
		.misLoadCommit(ev[13][0]), .misStoreCommit(ev[14][0]), .aluCount(ev[15]), .csrReadCommit(ev[16][0]),
		.csrRwCommit(ev[17][0]), .csrWrZeroCommit(ev[18][0]), .ebreakCommit(ev[19][0]), .ecallCommit(ev[20][0]),
		.fenceCommit(ev[21][0]), .fenceICommit(ev[22][0]), .mretCommit(ev[23][0]), .branchCommit(ev[24][0]),
		.branchMispredict(ev[25][0]), .branchTaken(ev[26][0]), .branchUnpredict(ev[27][0]), .fetchStall(ev[28][0]),
		.alignerStall(ev[29][0]), .decodeStall(ev[30][0]), .postSyncStall(ev[31][0]), .preSyncStall(ev[32][0]),
		.loadStoreFreeze(ev[33][0]), .storeBufferStall(ev[34][0]), .dataDmaStall(ev[35][0]),
		.instrDmaStall(ev[36][0]), .exceptionTaken(ev[37][0]), .timerIntTaken(tmr), .extIntTaken(ev[39][0]),
		.trapFlush(ev[40][0]), .branchErrFlush(ev[41][0]), .ibusTxn(ev[42][0]), .dbusTxn(ev[43][0]),
		.dbusMisaligned(ev[44][0]), .ibusError(ev[45][0]), .dbusError(ev[46][0]), .ibusBusy(ev[47][0]),
		.dbusBusy(ev[48][0]), .intStalledDisabled(isd));
	initial begin
		forever #5 clk = ~clk;
	end
	task automatic check_val(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check_val
	task automatic give_verdict();
		if (err_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : give_verdict
	// one cycle: check the state after the last edge, then drive new events and access, then advance the model
	task automatic step(input logic r, input logic w, input pesc_acc_e k, input logic [4:0] i, input logic [31:0] d);
		logic [63:0] nx;
		logic        hit;
		@(negedge clk);
		for (int c = 0; c < PESC_NUM_CNT; c++) begin
			check_val(cntOut[c], cnt[c]);
			check_val(64'(selOut[c]), 64'(sel[c]));
		end
		check_val(64'(grpEn), 64'(grp));
		check_val(64'(rdData), 64'(rdExp));
		rd = r;
		wr = w;
		kind = k;
		idx = i;
		wdata = d;
		halt = ($urandom % 8) == 0;
		mie = $urandom % 2;
		isd = $urandom % 2;
		tmr = 3'h1 << ($urandom % 4);
		for (int n = 2; n < PESC_NUM_EVT; n++)
			ev[n] = 2'($urandom % 2);
		ev[7] = 2'($urandom % 3);
		ev[8] = 2'($urandom % 3);
		ev[15] = 2'($urandom % 3);
		ev[5] = 2'($urandom % 3);
		ev[6] = 2'($urandom % (3 - ev[5]));
		ev[4] = ev[5] + ev[6];
		ev[1] = 2'h1;
		ev[38] = 2'(tmr != 3'h0);
		ev[49] = 2'(!mie);
		ev[50] = 2'(isd && !mie);
		if (r)
			rdExp = (k == PESC_ACC_GROUP) ? {31'h0000_0000, grp} : 32'h0000_0000;
		for (int c = 0; c < PESC_NUM_CNT; c++) begin
			hit = (i == 5'(c + 3)) && k != PESC_ACC_GROUP;
			nx = cnt[c] + ((grp && !halt) ? 64'(ev[sel[c]]) : 64'h0000_0000_0000_0000);
			if (r && hit)
				rdExp = k == PESC_ACC_SEL ? {26'h000_0000, sel[c]} : k == PESC_ACC_CNT_HI ? cnt[c][63:32] : cnt[c][31:0];
			if (w && hit && k == PESC_ACC_SEL)
				sel[c] = d > 32'h0000_0032 ? 6'h32 : d[5:0];
			if (w && hit && k == PESC_ACC_CNT_LO)
				nx[31:0] = d;
			if (w && hit && k == PESC_ACC_CNT_HI)
				nx[63:32] = d;
			cnt[c] = nx;
		end
		if (w && k == PESC_ACC_GROUP)
			grp = d[0];
	endtask : step
	always @(posedge clk) begin
		ticks++;
		if (ticks > 10000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		for (int n = 0; n < PESC_NUM_EVT; n++)
			ev[n] = 2'h0;
		for (int c = 0; c < PESC_NUM_CNT; c++) begin
			sel[c] = 6'h00;
			cnt[c] = 64'h0000_0000_0000_0000;
		end
		void'($urandom(15));
		repeat (10) @(negedge clk);
		sys_rst = 0;
		// every selector code, and codes above the top one, on each slot in turn
		for (int s = 0; s < 64; s++) begin
			step(1'b0, 1'b1, PESC_ACC_SEL, 5'(3 + s % 4), 32'(s));
			repeat (3) step(1'b1, 1'b0, PESC_ACC_CNT_LO, 5'(3 + s % 4), 32'h0000_0000);
		end
		// random traffic: back-to-back access, unimplemented slots, carries out of the low half
		repeat (3000) step($urandom % 2, ($urandom % 3) == 0, pesc_acc_e'($urandom % 4), 5'($urandom % 8 + 1),
			($urandom % 4) == 0 ? 32'hFFFF_FFFE : (($urandom % 2) == 0 ? 32'($urandom % 64) : $urandom));
		// one idle cycle so the last random edge is compared too
		step(1'b0, 1'b0, PESC_ACC_CNT_LO, 5'h03, 32'h0000_0000);
		give_verdict();
	end
endmodule : tb
`default_nettype wire

//--- src/perf_event_select_count.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - selector writes above fifty clamp to fifty
// - selector zero counts nothing; one counts cycles
// - selectors two, three count cache hits, misses
// - selectors four to six count committed instructions
// - selectors seven, eight count aligned, decoded instructions
// - selectors nine to fourteen count committed operations
// - selector fifteen counts ALU ops, NOP, WFI
// - selectors sixteen to eighteen count CSR instructions
// - selectors nineteen to twentythree count system instructions
// - selectors twentyfour to twentyseven count branch outcomes
// - selectors twentyeight to thirtytwo count front stalls
// - selectors thirtythree to thirtysix count freeze, DMA stalls
// - selectors thirtyseven to thirtynine count traps taken
// - selectors forty, fortyone count flushes
// - selectors fortytwo to fortysix count bus transactions
// - selectors fortyseven, fortyeight count bus busy stalls
// - selectors fortynine, fifty count interrupt-disabled cycles
// - only slots three to six exist; others zero
// - group enable, reset one, gates all counters
// - halt stops all counting, DMA included
// - counter increments after read, before write
module perf_event_select_count
	import pesc_pkg::*;
(
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               sys_rst,
	// control access from the core
	input  wire logic                               accRdEn,
	input  wire logic                               accWrEn,
	input  wire pesc_pkg::pesc_acc_e                accKind,
	input  wire logic [4:0]                         accIdx,
	input  wire logic [31:0]                        accWrData,
	output logic      [31:0]                        accRdData,
	// state seen by the core
	output logic                                    groupEnable,
	output logic      [pesc_pkg::PESC_NUM_CNT-1:0][5:0]  eventSelect,
	output logic      [pesc_pkg::PESC_NUM_CNT-1:0][63:0] counterValue,
	// core state
	input  wire logic                               coreHalted,
	input  wire logic                               mstatusMie,
	// fetch side events
	input  wire logic                               icacheHit,
	input  wire logic                               icacheMiss,
	input  wire logic [1:0]                         alignedCount,
	input  wire logic [1:0]                         decodedCount,
	// commit events
	input  wire logic [1:0]                         commit16Count,
	input  wire logic [1:0]                         commit32Count,
	input  wire logic                               mulCommit,
	input  wire logic                               divCommit,
	input  wire logic                               loadCommit,
	input  wire logic                               storeCommit,
	input  wire logic                               misLoadCommit,
	input  wire logic                               misStoreCommit,
	input  wire logic [1:0]                         aluCount,
	input  wire logic                               csrReadCommit,
	input  wire logic                               csrRwCommit,
	input  wire logic                               csrWrZeroCommit,
	input  wire logic                               ebreakCommit,
	input  wire logic                               ecallCommit,
	input  wire logic                               fenceCommit,
	input  wire logic                               fenceICommit,
	input  wire logic                               mretCommit,
	input  wire logic                               branchCommit,
	input  wire logic                               branchMispredict,
	input  wire logic                               branchTaken,
	input  wire logic                               branchUnpredict,
	// stall cycles
	input  wire logic                               fetchStall,
	input  wire logic                               alignerStall,
	input  wire logic                               decodeStall,
	input  wire logic                               postSyncStall,
	input  wire logic                               preSyncStall,
	input  wire logic                               loadStoreFreeze,
	input  wire logic                               storeBufferStall,
	input  wire logic                               dataDmaStall,
	input  wire logic                               instrDmaStall,
	// traps and flushes
	input  wire logic                               exceptionTaken,
	input  wire logic [2:0]                         timerIntTaken,
	input  wire logic                               extIntTaken,
	input  wire logic                               trapFlush,
	input  wire logic                               branchErrFlush,
	// bus activity, interrupt-disabled stall
	input  wire logic                               ibusTxn,
	input  wire logic                               dbusTxn,
	input  wire logic                               dbusMisaligned,
	input  wire logic                               ibusError,
	input  wire logic                               dbusError,
	input  wire logic                               ibusBusy,
	input  wire logic                               dbusBusy,
	input  wire logic                               intStalledDisabled
);
	import pesc_pkg::*;

	pesc_count_if cntBus ();

	logic countEnable;

	// halt freezes everything, the cycle event too
	assign countEnable = groupEnable & ~coreHalted;

	// event slots, each 0..2 per cycle
	always_comb begin
		for (int n = 0; n < PESC_NUM_EVT; n++) begin
			cntBus.evtCount[n] = 2'h0;
		end
		cntBus.evtCount[2]  = {1'b0, icacheHit};
		cntBus.evtCount[3]  = {1'b0, icacheMiss};
		cntBus.evtCount[4]  = 2'(commit16Count + commit32Count);
		cntBus.evtCount[5]  = commit16Count;
		cntBus.evtCount[6]  = commit32Count;
		cntBus.evtCount[7]  = alignedCount;
		cntBus.evtCount[8]  = decodedCount;
		cntBus.evtCount[9]  = {1'b0, mulCommit};
		cntBus.evtCount[10] = {1'b0, divCommit};
		cntBus.evtCount[11] = {1'b0, loadCommit};
		cntBus.evtCount[12] = {1'b0, storeCommit};
		cntBus.evtCount[13] = {1'b0, misLoadCommit};
		cntBus.evtCount[14] = {1'b0, misStoreCommit};
		// core reports NOP and WFI as ALU operations
		cntBus.evtCount[15] = aluCount;
		cntBus.evtCount[16] = {1'b0, csrReadCommit};
		cntBus.evtCount[17] = {1'b0, csrRwCommit};
		cntBus.evtCount[18] = {1'b0, csrWrZeroCommit};
		cntBus.evtCount[19] = {1'b0, ebreakCommit};
		cntBus.evtCount[20] = {1'b0, ecallCommit};
		cntBus.evtCount[21] = {1'b0, fenceCommit};
		cntBus.evtCount[22] = {1'b0, fenceICommit};
		cntBus.evtCount[23] = {1'b0, mretCommit};
		cntBus.evtCount[24] = {1'b0, branchCommit};
		cntBus.evtCount[25] = {1'b0, branchMispredict};
		cntBus.evtCount[26] = {1'b0, branchTaken};
		cntBus.evtCount[27] = {1'b0, branchUnpredict};
		cntBus.evtCount[28] = {1'b0, fetchStall};
		cntBus.evtCount[29] = {1'b0, alignerStall};
		cntBus.evtCount[30] = {1'b0, decodeStall};
		cntBus.evtCount[31] = {1'b0, postSyncStall};
		cntBus.evtCount[32] = {1'b0, preSyncStall};
		cntBus.evtCount[33] = {1'b0, loadStoreFreeze};
		cntBus.evtCount[34] = {1'b0, storeBufferStall};
		cntBus.evtCount[35] = {1'b0, dataDmaStall};
		cntBus.evtCount[36] = {1'b0, instrDmaStall};
		cntBus.evtCount[37] = {1'b0, exceptionTaken};
		// platform timer or either internal timer; one trap per cycle
		cntBus.evtCount[38] = {1'b0, |timerIntTaken};
		cntBus.evtCount[39] = {1'b0, extIntTaken};
		cntBus.evtCount[40] = {1'b0, trapFlush};
		cntBus.evtCount[41] = {1'b0, branchErrFlush};
		cntBus.evtCount[42] = {1'b0, ibusTxn};
		cntBus.evtCount[43] = {1'b0, dbusTxn};
		cntBus.evtCount[44] = {1'b0, dbusMisaligned};
		cntBus.evtCount[45] = {1'b0, ibusError};
		cntBus.evtCount[46] = {1'b0, dbusError};
		cntBus.evtCount[47] = {1'b0, ibusBusy};
		cntBus.evtCount[48] = {1'b0, dbusBusy};
		cntBus.evtCount[49] = {1'b0, ~mstatusMie};
		cntBus.evtCount[50] = {1'b0, intStalledDisabled & ~mstatusMie};
	end

	pesc_event_mux uEventMux (
		.cnt (cntBus.mux)
	);

	// group enable
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			groupEnable <= PESC_GROUP_EN_RESET;
		end else if (accWrEn && accKind == PESC_ACC_GROUP) begin
			groupEnable <= accWrData[0];
		end
	end

	for (genvar i = 0; i < PESC_NUM_CNT; i++) begin : gSlot
		logic        selHit;
		logic [63:0] next_count;

		assign selHit = pesc_idx_hit(accIdx, i);
		assign cntBus.sel[i] = eventSelect[i];

		// selector
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				eventSelect[i] <= PESC_SEL_RESET;
			end else if (accWrEn && accKind == PESC_ACC_SEL && selHit) begin
				eventSelect[i] <= pesc_clamp_sel(accWrData);
			end
		end

		// enable never touches the value, only the step
		assign next_count = countEnable ? counterValue[i] + {62'h0, cntBus.inc[i]}
			: counterValue[i];

		// a write lands on top of this cycle's step
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				counterValue[i] <= PESC_CNT_RESET;
			end else if (accWrEn && accKind == PESC_ACC_CNT_LO && selHit) begin
				counterValue[i] <= {next_count[63:32], accWrData};
			end else if (accWrEn && accKind == PESC_ACC_CNT_HI && selHit) begin
				counterValue[i] <= {accWrData, next_count[31:0]};
			end else begin
				counterValue[i] <= next_count;
			end
		end
	end

	// read data: value before this cycle's step
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			accRdData <= PESC_RD_RESET;
		end else if (accRdEn) begin
			accRdData <= PESC_RD_RESET;
			case (accKind)
				PESC_ACC_GROUP: begin
					accRdData <= {31'h0000_0000, groupEnable};
				end
				PESC_ACC_SEL: begin
					for (int k = 0; k < PESC_NUM_CNT; k++) begin
						if (pesc_idx_hit(accIdx, k)) begin
							accRdData <= {26'h000_0000, eventSelect[k]};
						end
					end
				end
				PESC_ACC_CNT_LO: begin
					for (int k = 0; k < PESC_NUM_CNT; k++) begin
						if (pesc_idx_hit(accIdx, k)) begin
							accRdData <= counterValue[k][31:0];
						end
					end
				end
				PESC_ACC_CNT_HI: begin
					for (int k = 0; k < PESC_NUM_CNT; k++) begin
						if (pesc_idx_hit(accIdx, k)) begin
							accRdData <= counterValue[k][63:32];
						end
					end
				end
				default: begin
					accRdData <= PESC_RD_RESET;
				end
			endcase
		end
	end

endmodule : perf_event_select_count
`default_nettype wire

//--- src/pesc_count_if.sv
`timescale 1ns/1ns
`default_nettype none
interface pesc_count_if;
	import pesc_pkg::*;

	logic [1:0]            evtCount [PESC_NUM_EVT];
	logic [PESC_SEL_W-1:0] sel      [PESC_NUM_CNT];
	logic [1:0]            inc      [PESC_NUM_CNT];

	modport src (output evtCount, output sel, input inc);
	modport mux (input evtCount, input sel, output inc);
endinterface : pesc_count_if
`default_nettype wire

//--- src/pesc_event_mux.sv
`timescale 1ns/1ns
`default_nettype none
module pesc_event_mux (
	// selectors in, per-counter increments out
	pesc_count_if.mux cnt
);
	import pesc_pkg::*;

	for (genvar i = 0; i < PESC_NUM_CNT; i++) begin : gSel
		always_comb begin
			case (cnt.sel[i])
				PESC_EVT_NONE:   cnt.inc[i] = 2'h0;
				PESC_EVT_CYCLES: cnt.inc[i] = 2'h1;
				default:         cnt.inc[i] = cnt.evtCount[cnt.sel[i]];
			endcase
		end
	end

endmodule : pesc_event_mux
`default_nettype wire

//--- src/pesc_pkg.sv
package pesc_pkg;

	// event numbering
	localparam int                 PESC_NUM_EVT    = 51;
	localparam int                 PESC_NUM_CNT    = 4;
	localparam int                 PESC_SEL_W      = 6;
	localparam logic [5:0]         PESC_EVT_NONE   = 6'h00;
	localparam logic [5:0]         PESC_EVT_CYCLES = 6'h01;
	localparam logic [5:0]         PESC_EVT_MAX    = 6'h32;

	// counter index window that is implemented
	localparam logic [4:0]         PESC_FIRST_CNT  = 5'h03;
	localparam logic [4:0]         PESC_LAST_CNT   = 5'h06;

	// reset values
	localparam logic               PESC_GROUP_EN_RESET = 1'b1;
	localparam logic [63:0]        PESC_CNT_RESET      = 64'h0000_0000_0000_0000;
	localparam logic [5:0]         PESC_SEL_RESET      = 6'h00;
	localparam logic [31:0]        PESC_RD_RESET       = 32'h0000_0000;

	// kind of access on the control port
	typedef enum logic [1:0] {
		PESC_ACC_CNT_LO,
		PESC_ACC_CNT_HI,
		PESC_ACC_SEL,
		PESC_ACC_GROUP
	} pesc_acc_e;

	// write-any/read-legal selector: anything above the top event becomes the top event
	function automatic logic [5:0] pesc_clamp_sel(input logic [31:0] value);
		if (value > {26'h000_0000, PESC_EVT_MAX}) begin
			return PESC_EVT_MAX;
		end
		return value[5:0];
	endfunction : pesc_clamp_sel

	// true when an access index names implemented counter slot
	function automatic logic pesc_idx_hit(input logic [4:0] idx, input int slot);
		return idx == (PESC_FIRST_CNT + slot[4:0]);
	endfunction : pesc_idx_hit

endpackage : pesc_pkg
